// *** core/jid_pkg.sv ***
// Constants, opcodes and carrier types for the test port instruction decoder.
// Assumes one system clock; the test pins are asynchronous to it.
package jid_pkg;
  localparam int IR_W = 5;
  localparam int ID_W = 32;
  localparam int CEN_W = 64;
  localparam int BSR_LEN = 16;
  localparam int DR_W = 64;
  localparam int AUX_MAX = 15;
  localparam int AUX_IDX_W = 4;
  localparam logic [IR_W-1:0] OP_IDCODE = 5'h01;
  localparam logic [IR_W-1:0] OP_PRELOAD = 5'h02;
  localparam logic [IR_W-1:0] OP_SAMPLE = 5'h03;
  localparam logic [IR_W-1:0] OP_EXTEST = 5'h04;
  localparam logic [IR_W-1:0] OP_CENSOR = 5'h07;
  localparam logic [IR_W-1:0] OP_CLAMP = 5'h0c;
  localparam logic [IR_W-1:0] OP_AUX_BASE = 5'h10;
  localparam logic [IR_W-1:0] OP_BYPASS = 5'h1f;
  localparam logic [IR_W-1:0] IR_CAPTURE = 5'h15;
  localparam logic [ID_W-1:0] ID_VALUE = 32'h0000_0001; // Arbitrary value
  localparam logic [CEN_W-1:0] CEN_RESET = 64'h0;

  typedef enum logic [1:0] {PATH_BYP, PATH_ID, PATH_BSR, PATH_CEN} jid_path_t;

  typedef enum {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } jid_tap_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jid_pins_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } jid_tdo_t;

  typedef struct packed {
    jid_path_t path;
    logic drive;
    logic freset;
    logic preload;
    logic aux;
    logic [AUX_IDX_W-1:0] aux_idx;
  } jid_dec_t;
endpackage

// *** core/jid_test_port_controller.sv ***
// Test port controller: TAP sequencing, instruction decode and data-path selection.
// Assumes TCK/TMS/TDI are asynchronous pins sampled by clk, and that auxiliary
// controllers run from the forwarded aux_tck and return aux_tdo asynchronously.

// Notes on behaviour
// - IDCODE opcode shifts 32-bit identification register
// - Sample/preload selects boundary chain, system undisturbed
// - Sample-only selects boundary chain, system undisturbed
// - Extest shifts boundary, drives pins, resets system
// - Censorship opcode shifts 64-bit control chain
// - Clamp uses bypass, drives pins, resets system
// - Aux opcodes grant port to one controller
// - Granted controller gets TDI/TMS, drives TDO
// - Port returns at Update-DR after Pause-DR
// - Idle auxiliary controllers held in Run-Test/Idle
// - Unimplemented aux opcodes act as bypass
// - Bypass opcode: one-bit path, system normal
// - Unassigned opcodes select the bypass stage
// - Factory debug codes give no guaranteed behaviour
// - Test reset loads the IDCODE instruction
// - Sample/preload captures pins in Capture-DR
// - Sample-only captures, then shifts toward TDO
// - Preload updates latches on falling Update-DR
// - Sample-only Update-DR changes nothing
// - State kept while TCK stands still
// - Five-bit IR captures 10101 in Capture-IR
// - All paths shift least significant bit first
// - Bypass stage captures zero in Capture-DR
// - Censorship hold loads at Update-DR, kept until test reset
module jid_test_port_controller #(
  parameter int unsigned auxiliary_tap_count = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire jid_pkg::jid_pins_t pins,
  output jid_pkg::jid_tdo_t tdo_pin,
  input wire logic [jid_pkg::BSR_LEN-1:0] bsr_sample,
  output logic [jid_pkg::BSR_LEN-1:0] bsr_hold,
  output logic bsr_drive,
  output logic func_reset,
  output logic [jid_pkg::CEN_W-1:0] censorship_control_chain,
  output logic censorship_chain_select,
  output logic aux_tck,
  output logic aux_tdi,
  output logic [jid_pkg::AUX_MAX-1:0] aux_tms,
  input wire logic [jid_pkg::AUX_MAX-1:0] aux_tdo
);
  import jid_pkg::*;

  function automatic jid_tap_t tap_step(jid_tap_t s, logic m);
    unique case (s)
      TLR: tap_step = m ? TLR : RTI;
      RTI: tap_step = m ? SEL_DR : RTI;
      SEL_DR: tap_step = m ? SEL_IR : CAP_DR;
      CAP_DR: tap_step = m ? EX1_DR : SH_DR;
      SH_DR: tap_step = m ? EX1_DR : SH_DR;
      EX1_DR: tap_step = m ? UPD_DR : PAU_DR;
      PAU_DR: tap_step = m ? EX2_DR : PAU_DR;
      EX2_DR: tap_step = m ? UPD_DR : SH_DR;
      UPD_DR: tap_step = m ? SEL_DR : RTI;
      SEL_IR: tap_step = m ? TLR : CAP_IR;
      CAP_IR: tap_step = m ? EX1_IR : SH_IR;
      SH_IR: tap_step = m ? EX1_IR : SH_IR;
      EX1_IR: tap_step = m ? UPD_IR : PAU_IR;
      PAU_IR: tap_step = m ? EX2_IR : PAU_IR;
      EX2_IR: tap_step = m ? UPD_IR : SH_IR;
      UPD_IR: tap_step = m ? SEL_DR : RTI;
    endcase
  endfunction

  function automatic jid_dec_t decode(logic [IR_W-1:0] op);
    decode = '{path: PATH_BYP, drive: 1'b0, freset: 1'b0, preload: 1'b0, aux: 1'b0, aux_idx: '0};
    unique case (op)
      OP_IDCODE: decode.path = PATH_ID;
      OP_PRELOAD: begin
        decode.path = PATH_BSR;
        decode.preload = 1'b1;
      end
      OP_SAMPLE: decode.path = PATH_BSR;
      OP_EXTEST: begin
        decode.path = PATH_BSR;
        decode.drive = 1'b1;
        decode.freset = 1'b1;
      end
      OP_CENSOR: decode.path = PATH_CEN;
      OP_CLAMP: begin
        decode.drive = 1'b1;
        decode.freset = 1'b1;
      end
      default: begin
        if (op >= OP_AUX_BASE && op != OP_BYPASS &&
            32'(op - OP_AUX_BASE) < auxiliary_tap_count) begin
          decode.aux = 1'b1;
          decode.aux_idx = AUX_IDX_W'(op - OP_AUX_BASE);
        end
      end
    endcase
  endfunction

  function automatic int path_len(jid_path_t p);
    unique case (p)
      PATH_ID: path_len = ID_W;
      PATH_BSR: path_len = BSR_LEN;
      PATH_CEN: path_len = CEN_W;
      PATH_BYP: path_len = 1;
    endcase
  endfunction

  // Three-stage sampling; a level counts only once stages two and three agree,
  // so a single unsettled sample cannot produce a double TCK edge
  jid_pins_t p1, p2, p3;
  logic [AUX_MAX-1:0] at1, at2, at3, at_lvl;
  logic tck_lvl;
  always_ff @(posedge clk) begin
    p1 <= pins;
    p2 <= p1;
    p3 <= p2;
    at1 <= aux_tdo;
    at2 <= at1;
    at3 <= at2;
    at_lvl <= (at2 & at3) | (at_lvl & (at2 | at3));
    tck_lvl <= (p2.tck & p3.tck) | (tck_lvl & (p2.tck | p3.tck));
  end

  logic rise, fall;
  assign rise = (p2.tck == p3.tck) && p3.tck && !tck_lvl;
  assign fall = (p2.tck == p3.tck) && !p3.tck && tck_lvl;

  jid_tap_t tap, next_tap;
  logic [IR_W-1:0] ir, next_ir, ir_sh, next_ir_sh;
  logic [DR_W-1:0] dr_sh, next_dr_sh;
  logic [BSR_LEN-1:0] next_bsr_hold;
  logic [CEN_W-1:0] next_cen;
  logic aux_act, next_aux_act, paused, next_paused;
  logic [AUX_IDX_W-1:0] aux_sel, next_aux_sel;
  jid_tdo_t next_tdo;
  logic next_drive, next_freset;
  logic [AUX_MAX-1:0] next_aux_tms;
  jid_dec_t dec, ndec;
  int len;

  assign dec = decode(ir);

  always_comb begin
    next_tap = tap;
    next_ir = ir;
    next_ir_sh = ir_sh;
    next_dr_sh = dr_sh;
    next_bsr_hold = bsr_hold;
    next_cen = censorship_control_chain;
    next_aux_act = aux_act;
    next_paused = paused;
    next_aux_sel = aux_sel;
    next_tdo = tdo_pin;
    len = path_len(dec.path);
    // Below, only the granted TDO mirror, the test-reset loads and aux TMS act without a detected TCK edge
    if (rise) begin
      next_tap = tap_step(tap, p2.tms);
      if (aux_act) begin
        if (tap == PAU_DR) next_paused = 1'b1;
        if (tap == UPD_DR && paused) begin
          next_aux_act = 1'b0;
          next_paused = 1'b0;
          next_ir = OP_BYPASS;
        end
      end else begin
        unique case (tap)
          CAP_IR: next_ir_sh = IR_CAPTURE;
          SH_IR: next_ir_sh = {p2.tdi, ir_sh[IR_W-1:1]};
          CAP_DR: begin
            unique case (dec.path)
              PATH_ID: next_dr_sh[ID_W-1:0] = {ID_VALUE[ID_W-1:1], 1'b1};
              PATH_BSR: next_dr_sh[BSR_LEN-1:0] = bsr_sample;
              PATH_CEN: next_dr_sh[CEN_W-1:0] = censorship_control_chain;
              PATH_BYP: next_dr_sh[0] = 1'b0;
            endcase
          end
          SH_DR: begin
            next_dr_sh = dr_sh >> 1;
            next_dr_sh[len-1] = p2.tdi;
          end
          UPD_DR: if (dec.path == PATH_CEN) next_cen = dr_sh[CEN_W-1:0];
          default: ;
        endcase
      end
    end
    if (fall && !aux_act) begin
      if (tap == UPD_IR) begin
        next_ir = ir_sh;
        ndec = decode(ir_sh);
        next_aux_act = ndec.aux;
        next_aux_sel = ndec.aux_idx;
        next_paused = 1'b0;
      end
      // Sample-only never reaches the latches
      if (tap == UPD_DR && dec.preload) next_bsr_hold = dr_sh[BSR_LEN-1:0];
      next_tdo.tdo_oe = (tap == SH_IR) || (tap == SH_DR);
      if (tap == SH_IR) next_tdo.tdo = ir_sh[0];
      if (tap == SH_DR) next_tdo.tdo = dr_sh[0];
    end
    if (aux_act) begin
      next_tdo.tdo = at_lvl[aux_sel];
      next_tdo.tdo_oe = 1'b1;
    end
    if (tap == TLR) begin
      next_ir = OP_IDCODE;
      next_cen = CEN_RESET;
      next_aux_act = 1'b0;
      next_paused = 1'b0;
    end
    ndec = decode(next_ir);
    next_drive = ndec.drive;
    next_freset = ndec.freset;
    for (int k = 0; k < AUX_MAX; k++) begin
      next_aux_tms[k] = next_aux_act && next_aux_sel == AUX_IDX_W'(k) && p2.tms;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tap <= TLR;
      ir <= OP_IDCODE;
      ir_sh <= '0;
      dr_sh <= '0;
      bsr_hold <= '0;
      censorship_control_chain <= CEN_RESET;
      aux_act <= 1'b0;
      paused <= 1'b0;
      aux_sel <= '0;
      tdo_pin <= '0;
      bsr_drive <= 1'b0;
      func_reset <= 1'b0;
      aux_tms <= '0;
      aux_tck <= 1'b0;
      aux_tdi <= 1'b0;
    end else begin
      tap <= next_tap;
      ir <= next_ir;
      ir_sh <= next_ir_sh;
      dr_sh <= next_dr_sh;
      bsr_hold <= next_bsr_hold;
      censorship_control_chain <= next_cen;
      aux_act <= next_aux_act;
      paused <= next_paused;
      aux_sel <= next_aux_sel;
      tdo_pin <= next_tdo;
      bsr_drive <= next_drive;
      func_reset <= next_freset;
      aux_tms <= next_aux_tms;
      aux_tck <= p2.tck;
      aux_tdi <= p2.tdi;
    end
  end

  assign censorship_chain_select = (dec.path == PATH_CEN) && !aux_act;

  a_ir_reset: assert property (@(posedge clk) disable iff (!resetn) tap == TLR |=> ir == OP_IDCODE)
    else $error("IR not IDCODE after test reset");
  a_ir_capture: assert property (@(posedge clk) disable iff (!resetn)
    rise && tap == CAP_IR && !aux_act |=> ir_sh == IR_CAPTURE)
    else $error("IR capture value wrong");
  a_bypass_zero: assert property (@(posedge clk) disable iff (!resetn)
    rise && tap == CAP_DR && !aux_act && dec.path == PATH_BYP |=> dr_sh[0] == 1'b0)
    else $error("Bypass stage not cleared");
  a_id_capture: assert property (@(posedge clk) disable iff (!resetn)
    rise && tap == CAP_DR && !aux_act && ir == OP_IDCODE |=> dr_sh[ID_W-1:0] == {ID_VALUE[ID_W-1:1], 1'b1})
    else $error("ID capture wrong");
  a_extest_drive: assert property (@(posedge clk) disable iff (!resetn)
    ir == OP_EXTEST ##1 ir == OP_EXTEST |-> bsr_drive && func_reset)
    else $error("Extest not driving pins or reset");
  a_clamp_drive: assert property (@(posedge clk) disable iff (!resetn)
    ir == OP_CLAMP ##1 ir == OP_CLAMP |-> bsr_drive && func_reset && dec.path == PATH_BYP)
    else $error("Clamp decode wrong");
  a_bypass_normal: assert property (@(posedge clk) disable iff (!resetn)
    ir == OP_BYPASS ##1 ir == OP_BYPASS |-> !bsr_drive && !func_reset)
    else $error("Bypass disturbs system");
  a_preload_quiet: assert property (@(posedge clk) disable iff (!resetn)
    ir == OP_PRELOAD ##1 ir == OP_PRELOAD |-> !bsr_drive && !func_reset)
    else $error("Preload disturbs system");
  a_sample_quiet: assert property (@(posedge clk) disable iff (!resetn)
    ir == OP_SAMPLE ##1 ir == OP_SAMPLE |-> !bsr_drive && !func_reset)
    else $error("Sample disturbs system");
  a_sample_still: assert property (@(posedge clk) disable iff (!resetn)
    fall && tap == UPD_DR && ir == OP_SAMPLE |=> $stable(bsr_hold))
    else $error("Sample-only changed latches");
  a_censor_hold: assert property (@(posedge clk) disable iff (!resetn)
    rise && tap == UPD_DR && !aux_act && ir == OP_CENSOR |=> censorship_control_chain == $past(dr_sh))
    else $error("Censorship hold not loaded");
  a_aux_idle: assert property (@(posedge clk) disable iff (!resetn)
    !aux_act ##1 !aux_act |-> aux_tms == '0)
    else $error("Idle aux controller sees TMS");
  a_aux_tdo: assert property (@(posedge clk) disable iff (!resetn)
    aux_act ##1 aux_act |-> tdo_pin.tdo_oe)
    else $error("Granted controller not driving TDO");
  a_aux_return: assert property (@(posedge clk) disable iff (!resetn)
    rise && aux_act && tap == UPD_DR && paused |=> !aux_act && ir == OP_BYPASS)
    else $error("Port not reclaimed");

  c_aux_grant: cover property (@(posedge clk) disable iff (!resetn) !aux_act ##1 aux_act);
  c_extest: cover property (@(posedge clk) disable iff (!resetn) bsr_drive && tap == SH_DR);
  c_censor: cover property (@(posedge clk) disable iff (!resetn) rise && tap == UPD_DR && ir == OP_CENSOR);
  c_aux_back: cover property (@(posedge clk) disable iff (!resetn) aux_act ##1 !aux_act);
  c_sample: cover property (@(posedge clk) disable iff (!resetn) fall && tap == UPD_DR && ir == OP_SAMPLE);
endmodule

// *** testbench/jid_tester.sv ***
// Tester model: drives the test pins and samples TDO before each TCK rise.
// Assumes clk at 100 MHz; TCK period is 16 clk and TCK stands high between frames.
module jid_tester (
  input wire logic clk,
  output jid_pkg::jid_pins_t pins,
  input wire jid_pkg::jid_tdo_t tdo_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import jid_pkg::*;
  initial pins = '0;
  // TMS/TDI move with the fall, eight clk ahead of the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(posedge clk);
    pins <= '{tck: 1'b0, tms: tms, tdi: tdi};
    repeat (8) @(posedge clk);
    tdo = tdo_pin.tdo;
    pins.tck <= 1'b1;
    repeat (7) @(posedge clk);
  endtask
  task automatic shift(input int n, input logic [63:0] din, output logic [63:0] dout);
    logic b;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
  endtask
  task automatic dr(input int n, input logic [63:0] din, output logic [63:0] dout);
    logic b;
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    shift(n, din, dout);
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask
  // Instruction load starts from Run-Test/Idle and ends back in Run-Test/Idle
  task automatic ir(input logic [4:0] op, output logic [63:0] dout);
    logic b;
    step(1'b1, 1'b0, b);
    dr(5, {59'h0, op}, dout);
  endtask
  task automatic tlr();
    logic b;
    repeat (5) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the test port controller.
// Assumes the tester model drives the pins; the bench stands in for aux controllers.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import jid_pkg::*;
  logic clk, resetn, drv, frst, csel, b, atck, atdi;
  jid_pins_t pins;
  jid_tdo_t tdo_pin;
  logic [BSR_LEN-1:0] bsr_sample, bsr_hold;
  logic [CEN_W-1:0] cen;
  logic [AUX_MAX-1:0] aux_tms, aux_tdo;
  logic [63:0] q;
  localparam logic [63:0] PAT = 64'h0123_4567_89ab_cdef;
  logic [4:0] byp [5] = '{OP_BYPASS, 5'h08, 5'h05, 5'h14, 5'h1e};
  int error_cnt = 0;
  int compares = 0;
  jid_test_port_controller #(.auxiliary_tap_count(4)) dut_u (.clk(clk), .resetn(resetn),
    .pins(pins), .tdo_pin(tdo_pin), .bsr_sample(bsr_sample), .bsr_hold(bsr_hold),
    .bsr_drive(drv), .func_reset(frst), .censorship_control_chain(cen),
    .censorship_chain_select(csel), .aux_tck(atck), .aux_tdi(atdi), .aux_tms(aux_tms), .aux_tdo(aux_tdo));
  jid_tester tst_u (.clk(clk), .pins(pins), .tdo_pin(tdo_pin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic t_ident();
    tst_u.step(1'b0, 1'b0, b);
    check("ctl", {drv, frst}, 2'b00);
    tst_u.dr(32, 64'h0, q);
    check("id", q, {ID_VALUE[31:1], 1'b1});
    tst_u.ir(OP_BYPASS, q);
    check("ircap", q, IR_CAPTURE);
  endtask
  task automatic t_bypass();
    foreach (byp[i]) begin
      tst_u.ir(byp[i], q);
      tst_u.dr(2, 64'h3, q);
      check("byp", q, 64'h2);
      check("bctl", {drv, frst}, 2'b00);
    end
  endtask
  task automatic t_bound();
    bsr_sample <= 16'ha5c3;
    tst_u.ir(OP_PRELOAD, q);
    tst_u.dr(16, 64'h3c5a, q);
    check("pcap", q, 64'ha5c3);
    check("phold", bsr_hold, 16'h3c5a);
    check("pctl", {drv, frst}, 2'b00);
    bsr_sample <= 16'h0ff0;
    tst_u.ir(OP_SAMPLE, q);
    tst_u.dr(16, 64'hffff, q);
    check("scap", q, 64'h0ff0);
    check("shold", bsr_hold, 16'h3c5a);
    check("sctl", {drv, frst}, 2'b00);
    tst_u.ir(OP_EXTEST, q);
    check("xctl", {drv, frst}, 2'b11);
    tst_u.dr(17, 64'h1, q);
    check("xlen", q, 64'h1_0ff0);
    check("xhold", bsr_hold, 16'h3c5a);
    tst_u.ir(OP_CLAMP, q);
    check("cctl", {drv, frst}, 2'b11);
    tst_u.dr(2, 64'h3, q);
    check("clen", q, 64'h2);
  endtask
  task automatic t_censor();
    tst_u.ir(OP_CENSOR, q);
    check("csel", csel, 1'b1);
    tst_u.dr(64, PAT, q);
    check("chold", cen, PAT);
    tst_u.dr(64, ~PAT, q);
    check("ccap", q, PAT);
    check("chold2", cen, ~PAT);
    tst_u.tlr();
    check("cclr", cen, 64'h0);
    tst_u.dr(1, 64'h0, q);
    check("tlrid", q, 64'h1);
  endtask
  task automatic t_aux();
    aux_tdo <= 15'h0002;
    tst_u.ir(OP_AUX_BASE + 5'h01, q);
    tst_u.step(1'b1, 1'b1, b);
    check("atdo1", b, 1'b1);
    check("aoe", tdo_pin.tdo_oe, 1'b1);
    check("afwd", {atck, atdi}, 2'b11);
    check("atms", aux_tms, 15'h0002);
    aux_tdo <= 15'h7ffd;
    tst_u.step(1'b0, 1'b0, b);
    tst_u.step(1'b0, 1'b0, b);
    check("atdo0", b, 1'b0);
    tst_u.step(1'b1, 1'b0, b);
    tst_u.step(1'b0, 1'b0, b);
    tst_u.step(1'b1, 1'b0, b);
    tst_u.step(1'b1, 1'b0, b);
    tst_u.step(1'b0, 1'b0, b);
    check("aidle", aux_tms, 15'h0);
    tst_u.dr(2, 64'h3, q);
    check("areclaim", q, 64'h2);
    check("aoe0", tdo_pin.tdo_oe, 1'b0);
  endtask
  initial begin
    resetn = 1'b0;
    bsr_sample = '0;
    aux_tdo = '0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_ident();
    t_bypass();
    t_bound();
    t_censor();
    t_aux();
    complete_run();
  end
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
endmodule
